/* src/dpd_pkg.sv */
// Shared constants for the dual synthesizer control block.
// Assumes a 22-bit serial word, latch select code in the two LSBs.
package dpd_pkg;

	localparam int SHIFT_W = 22;

	// Latch select codes
	localparam logic [1:0] SEL_IF_REF = 2'h0;
	localparam logic [1:0] SEL_IF_AB = 2'h1;
	localparam logic [1:0] SEL_RF_REF = 2'h2;
	localparam logic [1:0] SEL_RF_AB = 2'h3;

	// Field positions inside a latch
	localparam int POS_PD = 21;
	localparam int POS_PRESC = 20;
	localparam int POS_MUX_HI = 21;
	localparam int POS_MUX_LO = 20;
	localparam int POS_R_LSB = 2;
	localparam int POS_A_LSB = 2;
	localparam int B_LSB_B11 = 9;
	localparam int B_LSB_B13 = 7;

	// Prescaler moduli P (P+1 is the other modulus)
	localparam logic [6:0] MOD_IF_LO = 7'h08;
	localparam logic [6:0] MOD_IF_HI = 7'h10;
	localparam logic [6:0] MOD_RF_B11_LO = 7'h20;
	localparam logic [6:0] MOD_RF_B11_HI = 7'h40;
	localparam logic [6:0] MOD_RF_B13_LO = 7'h10;
	localparam logic [6:0] MOD_RF_B13_HI = 7'h20;

	localparam logic [21:0] LATCH_RST = 22'h000000;

	// Register map, byte addresses
	localparam logic [11:0] ADDR_IF_REF = 12'h000;
	localparam logic [11:0] ADDR_IF_AB = 12'h004;
	localparam logic [11:0] ADDR_RF_REF = 12'h008;
	localparam logic [11:0] ADDR_RF_AB = 12'h00c;
	localparam logic [11:0] ADDR_DIRECT = 12'h010;
	localparam logic [11:0] ADDR_SHIFT = 12'h014;
	localparam logic [11:0] ADDR_STATUS = 12'h018;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Test output source, code is {rf_hi, rf_lo, if_hi, if_lo}
	typedef enum logic [3:0] {
		MUX_LOW = 4'h0,
		MUX_IF_LOCK = 4'h1,
		MUX_IF_REF = 4'h2,
		MUX_IF_FB = 4'h3,
		MUX_RF_LOCK = 4'h4,
		MUX_BOTH_LOCK = 4'h5,
		MUX_RF_REF = 4'h6,
		MUX_RF_FB = 4'h7
	} dpd_mux_e;

endpackage

/* src/dpd_div_if.sv */
// Configuration and divider outputs for one synthesizer side.
// Settings driven by the control top, pulses driven by the two divider modules.
`timescale 1ns/1ps
interface dpd_div_if #(
	parameter int A_W = 6,
	parameter int B_W = 11,
	parameter int R_W = 14
);
	logic in_tick;
	logic ref_tick;
	logic run;
	logic [A_W-1:0] a;
	logic [B_W-1:0] b;
	logic [R_W-1:0] r;
	logic [6:0] p;
	logic fb_pulse;
	logic ref_pulse;

	modport ctl(output in_tick, ref_tick, run, a, b, p, r, input fb_pulse, ref_pulse);
	modport fb(input in_tick, run, a, b, p, output fb_pulse);
	modport rdiv(input ref_tick, run, r, output ref_pulse);
endinterface

/* src/dpd_fb_div.sv */
// Dual-modulus prescaler with A and B counters, N = B*P + A.
// Assumes in_tick marks one input cycle; B >= A and B >= 1.
`timescale 1ns/1ps
module dpd_fb_div #(
	parameter int A_W = 6,
	parameter int B_W = 11
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	dpd_div_if.fb d
);

	logic [6:0] pre;
	logic [A_W-1:0] a_left;
	logic [B_W-1:0] b_left;
	logic pre_end;
	logic n_end;

	// (R19) P+1 while A runs; a smaller P mid-count ends at once, no wrap
	assign pre_end = d.in_tick && (pre >= ((a_left != '0) ? d.p : d.p - 7'h01));
	assign n_end = pre_end && (b_left <= B_W'(1));

	// (R7) B cycles, A of them long
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !d.run) begin
			pre <= 7'h00;
			a_left <= d.a;
			b_left <= d.b;
			d.fb_pulse <= 1'b0;
		end else begin
			d.fb_pulse <= n_end;
			if (d.in_tick)
				pre <= pre_end ? 7'h00 : pre + 7'h01;
			if (n_end) begin
				a_left <= d.a;
				b_left <= d.b;
			end else if (pre_end) begin
				if (a_left != '0)
					a_left <= a_left - A_W'(1);
				b_left <= b_left - B_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Checking helpers: ticks per feedback cycle under steady setup
	logic [31:0] tcnt;
	logic primed;
	logic steady;
	logic [A_W+B_W+6:0] cfg_q;

	assign steady = (cfg_q == {d.a, d.b, d.p}) && d.run;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tcnt <= 32'h0;
			primed <= 1'b0;
			cfg_q <= '0;
		end else begin
			cfg_q <= {d.a, d.b, d.p};
			if (n_end || !d.run)
				tcnt <= 32'h0;
			else if (d.in_tick)
				tcnt <= tcnt + 32'h1;
			if (!steady)
				primed <= 1'b0;
			else if (n_end)
				primed <= 1'b1;
		end
	end

	fb_ratio_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R7)
		(n_end && primed && steady && d.b != '0 && d.b >= B_W'(d.a))
		|-> (int'(tcnt) + 1 == int'(d.b) * int'(d.p) + int'(d.a)))
		else $error("feedback ratio differs from B*P+A");

endmodule

/* src/dpd_ref_div.sv */
// Reference divider, one pulse per R reference cycles.
// Assumes ref_tick marks one reference cycle; R of 0 acts as 1.
`timescale 1ns/1ps
module dpd_ref_div #(
	parameter int R_W = 14
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	dpd_div_if.rdiv d
);

	logic [R_W-1:0] cnt;
	logic r_end;

	// A smaller R mid-count ends at once instead of wrapping
	assign r_end = d.ref_tick && ((d.r <= R_W'(1)) || (cnt >= d.r - R_W'(1)));

	// (R10) Divide by 1 to full scale
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !d.run) begin
			cnt <= '0;
			d.ref_pulse <= 1'b0;
		end else begin
			d.ref_pulse <= r_end;
			if (d.ref_tick)
				cnt <= r_end ? '0 : cnt + R_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////
	logic [31:0] tcnt;
	logic primed;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tcnt <= 32'h0;
			primed <= 1'b0;
		end else begin
			if (r_end || !d.run)
				tcnt <= 32'h0;
			else if (d.ref_tick)
				tcnt <= tcnt + 32'h1;
			if (!d.run || $changed(d.r))
				primed <= 1'b0;
			else if (r_end)
				primed <= 1'b1;
		end
	end

	ref_ratio_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R11)
		(r_end && primed && d.r != '0 && $stable(d.r)) |-> (int'(tcnt) + 1 == int'(d.r)))
		else $error("reference ratio differs from R");

endmodule

/* src/dpd_ctrl.sv */
// Serial-programmed control of a dual synthesizer, with AXI4-Lite view.
// Assumes serial, load and divider inputs synchronous to i_sys_clk.
//
// How it works
// (R1) Serial data shifts into a 22-bit register on each serial clock rise.
// (R2) Host sends MSB first; the last two bits are the latch select.
// (R3) Load strobe rise copies the shift register into one of four latches.
// (R4) IF prescaler is 8/9 when bit 20 is 0, 16/17 when 1.
// (R5) Eleven-bit B variant: RF prescaler selectable 64/65 or 32/33.
// (R6) Thirteen-bit B variant: RF prescaler selectable 16/17 or 32/33.
// (R7) Feedback divide ratio is B times P plus A.
// (R8) B counter is binary, 11 or 13 bits by variant.
// (R9) A counter is binary, 6 or 5 bits by variant.
// (R10) Fourteen-bit reference divider divides by any ratio 1 to 16383.
// (R11) With the extra top bit, reference ratio reaches 32767.
// (R12) Host keeps prescaler output at or below 188 MHz.
// (R13) Output step is reference divided by R; frequency is N times that.
// (R14) Test output can show lock detect, feedback or reference divider.
// (R15) Power-down isolates the reference input buffer; here only when both IF and RF are powered down.
// (R16) Select 00 IF ref, 01 IF counter, 10 RF ref, 11 RF counter.
// (R17) Four bits in the two reference latches choose the test output.
// (R18) Lock detect on test output is high while locked, narrow low pulses.
// (R19) Prescaler runs P+1 until A expires, P for the rest, then reload.
// (R20) Host keeps load strobe low while shifting, and B not below A.
`timescale 1ns/1ps
module dpd_ctrl #(
	parameter bit B13 = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ser_clk,
	input wire logic i_ser_data,
	input wire logic i_load_strobe,
	input wire logic i_reference_input,
	input wire logic i_if_input,
	input wire logic i_rf_input,
	input wire logic i_if_lock,
	input wire logic i_rf_lock,
	input wire logic [11:0] i_axi_awaddr,
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	output logic [1:0] o_axi_bresp,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	input wire logic [11:0] i_axi_araddr,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	output logic o_if_ref_pulse,
	output logic o_if_fb_pulse,
	output logic o_rf_ref_pulse,
	output logic o_rf_fb_pulse,
	output logic o_if_power_down,
	output logic o_rf_power_down,
	output logic o_ref_input_isolation_switch,
	output logic o_test_mux_output,
	output logic o_test_mux_oe
);

	localparam int A_W = B13 ? 5 : 6;
	localparam int B_W = B13 ? 13 : 11;
	localparam int R_W = B13 ? 15 : 14;
	localparam int B_LSB = B13 ? dpd_pkg::B_LSB_B13 : dpd_pkg::B_LSB_B11;

	////////////////////////////////////////////////////////////////
	// Input edges
	logic sclk_q;
	logic load_q;
	logic ref_q;
	logic if_q;
	logic rf_q;
	logic sclk_rise;
	logic load_rise;
	logic ref_tick;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sclk_q <= 1'b0;
			load_q <= 1'b0;
			ref_q <= 1'b0;
			if_q <= 1'b0;
			rf_q <= 1'b0;
		end else begin
			sclk_q <= i_ser_clk;
			load_q <= i_load_strobe;
			ref_q <= i_reference_input;
			if_q <= i_if_input;
			rf_q <= i_rf_input;
		end
	end

	assign sclk_rise = i_ser_clk && !sclk_q;
	assign load_rise = i_load_strobe && !load_q;
	// (R15) Isolated buffer passes no edges
	assign ref_tick = i_reference_input && !ref_q && !o_ref_input_isolation_switch;

	////////////////////////////////////////////////////////////////
	// Shift register and latches
	logic [21:0] sreg;
	logic [21:0] lat [4];
	logic direct_load;
	logic [21:0] direct_word;

	// (R1) MSB first, new bit at bit 0
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			sreg <= dpd_pkg::LATCH_RST;
		else if (sclk_rise)
			sreg <= {sreg[20:0], i_ser_data};
	end

	shift_capture_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R1)
		sclk_rise |=> (sreg == {$past(sreg[20:0]), $past(i_ser_data)}))
		else $error("serial bit not captured");

	// Serial load wins over a bus load in the same cycle
	for (genvar k = 0; k < 4; k++) begin : g_lat
		// (R3) One latch per load
		always_ff @(posedge i_sys_clk) begin
			if (i_rst)
				lat[k] <= dpd_pkg::LATCH_RST;
			else if (load_rise) begin
				// (R16) Select from two LSBs
				if (sreg[1:0] == 2'(k))
					lat[k] <= sreg;
			end else if (direct_load && direct_word[1:0] == 2'(k))
				lat[k] <= direct_word;
		end
	end

	latch_load_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R16)
		(load_rise && sreg[1:0] == dpd_pkg::SEL_RF_AB)
		|=> (lat[3] == $past(sreg)) && $stable(lat[0]) && $stable(lat[2]))
		else $error("wrong latch loaded");

	////////////////////////////////////////////////////////////////
	// Per-side dividers: IF uses latches 0/1, RF uses 2/3
	for (genvar s = 0; s < 2; s++) begin : g_side
		dpd_div_if #(.A_W(A_W), .B_W(B_W), .R_W(R_W)) dv();

		logic psel;
		assign psel = lat[2*s+1][dpd_pkg::POS_PRESC];

		assign dv.run = !lat[2*s+1][dpd_pkg::POS_PD];
		assign dv.in_tick = (s == 0) ? (i_if_input && !if_q) : (i_rf_input && !rf_q);
		assign dv.ref_tick = ref_tick;
		// (R9) A field width by variant
		assign dv.a = lat[2*s+1][dpd_pkg::POS_A_LSB +: A_W];
		// (R8) B field width by variant
		assign dv.b = lat[2*s+1][B_LSB +: B_W];
		// (R11) Top bit used in wide variant
		assign dv.r = lat[2*s][dpd_pkg::POS_R_LSB +: R_W];

		if (s == 0) begin : g_if
			// (R4) IF modulus select
			assign dv.p = psel ? dpd_pkg::MOD_IF_HI : dpd_pkg::MOD_IF_LO;
		end else if (B13) begin : g_rf13
			// (R6) RF modulus, narrow A
			assign dv.p = psel ? dpd_pkg::MOD_RF_B13_HI : dpd_pkg::MOD_RF_B13_LO;
		end else begin : g_rf11
			// (R5) RF modulus, wide A
			assign dv.p = psel ? dpd_pkg::MOD_RF_B11_HI : dpd_pkg::MOD_RF_B11_LO;
		end

		// (R13) N divider and R divider pair
		dpd_fb_div #(.A_W(A_W), .B_W(B_W)) u_fb (
			.i_sys_clk(i_sys_clk),
			.i_rst(i_rst),
			.d(dv.fb)
		);

		dpd_ref_div #(.R_W(R_W)) u_ref (
			.i_sys_clk(i_sys_clk),
			.i_rst(i_rst),
			.d(dv.rdiv)
		);
	end

	if_presc_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R4)
		$rose(lat[1][dpd_pkg::POS_PRESC]) |-> (g_side[0].dv.p == 7'h10)
		##1 (g_side[0].dv.p == 7'h10))
		else $error("IF prescaler not 16/17");

	rf_presc_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R5)
		!lat[3][dpd_pkg::POS_PRESC] |-> (g_side[1].dv.p == (B13 ? 7'h10 : 7'h20)))
		else $error("RF prescaler low modulus wrong");

	////////////////////////////////////////////////////////////////
	// Divider outputs, power-down and reference isolation
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_if_ref_pulse <= 1'b0;
			o_if_fb_pulse <= 1'b0;
			o_rf_ref_pulse <= 1'b0;
			o_rf_fb_pulse <= 1'b0;
			o_if_power_down <= 1'b0;
			o_rf_power_down <= 1'b0;
			o_ref_input_isolation_switch <= 1'b0;
		end else begin
			o_if_ref_pulse <= g_side[0].dv.ref_pulse;
			o_if_fb_pulse <= g_side[0].dv.fb_pulse;
			o_rf_ref_pulse <= g_side[1].dv.ref_pulse;
			o_rf_fb_pulse <= g_side[1].dv.fb_pulse;
			o_if_power_down <= lat[1][dpd_pkg::POS_PD];
			o_rf_power_down <= lat[3][dpd_pkg::POS_PD];
			// (R15) Shared buffer, open only when both sides sleep
			o_ref_input_isolation_switch <= lat[1][dpd_pkg::POS_PD] && lat[3][dpd_pkg::POS_PD];
		end
	end

	iso_switch_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R15)
		(lat[1][dpd_pkg::POS_PD] && lat[3][dpd_pkg::POS_PD]) [*2]
		|-> o_ref_input_isolation_switch && !ref_tick)
		else $error("reference input not isolated");

	////////////////////////////////////////////////////////////////
	// Test output multiplexer
	logic [3:0] mux_code;
	logic next_mux;
	logic next_oe;

	// (R17) Two bits from each reference latch
	assign mux_code = {lat[2][dpd_pkg::POS_MUX_HI], lat[2][dpd_pkg::POS_MUX_LO],
		lat[0][dpd_pkg::POS_MUX_HI], lat[0][dpd_pkg::POS_MUX_LO]};

	// (R14) Lock, feedback or reference view
	always_comb begin
		next_mux = 1'b0;
		next_oe = 1'b1;
		unique case (dpd_pkg::dpd_mux_e'(mux_code))
			dpd_pkg::MUX_LOW: next_mux = 1'b0;
			// (R18) Lock level passes with its pulses
			dpd_pkg::MUX_IF_LOCK: next_mux = i_if_lock;
			dpd_pkg::MUX_IF_REF: next_mux = g_side[0].dv.ref_pulse;
			dpd_pkg::MUX_IF_FB: next_mux = g_side[0].dv.fb_pulse;
			dpd_pkg::MUX_RF_LOCK: next_mux = i_rf_lock;
			dpd_pkg::MUX_BOTH_LOCK: next_mux = i_if_lock && i_rf_lock;
			dpd_pkg::MUX_RF_REF: next_mux = g_side[1].dv.ref_pulse;
			dpd_pkg::MUX_RF_FB: next_mux = g_side[1].dv.fb_pulse;
			default: next_oe = 1'b0;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_test_mux_output <= 1'b0;
			o_test_mux_oe <= 1'b1;
		end else begin
			o_test_mux_output <= next_mux;
			o_test_mux_oe <= next_oe;
		end
	end

	mux_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R18)
		(mux_code == 4'h1) |=> (o_test_mux_output == $past(i_if_lock)) && o_test_mux_oe)
		else $error("lock detect not on test output");

	mux_rf_fb_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // (R14)
		(mux_code == 4'h7 && g_side[1].dv.fb_pulse) |=> o_test_mux_output && o_rf_fb_pulse)
		else $error("RF feedback not on test output");

	////////////////////////////////////////////////////////////////
	// AXI4-Lite slave, one write and one read at a time
	logic have_aw;
	logic have_w;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_take;
	logic w_take;
	logic wr_fire;

	assign aw_take = i_axi_awvalid && o_axi_awready;
	assign w_take = i_axi_wvalid && o_axi_wready;
	assign wr_fire = have_aw && have_w && !o_axi_bvalid;
	// Partial strobes would split a word, so they are ignored
	assign direct_load = wr_fire && aw_addr == dpd_pkg::ADDR_DIRECT && w_strb[2:0] == 3'h7;
	assign direct_word = w_data[21:0];

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			o_axi_awready <= 1'b0;
			o_axi_wready <= 1'b0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp <= dpd_pkg::RESP_OKAY;
		end else begin
			o_axi_awready <= !(have_aw || aw_take) || wr_fire;
			o_axi_wready <= !(have_w || w_take) || wr_fire;
			if (aw_take) begin
				have_aw <= 1'b1;
				aw_addr <= {i_axi_awaddr[11:2], 2'h0};
			end
			if (w_take) begin
				have_w <= 1'b1;
				w_data <= i_axi_wdata;
				w_strb <= i_axi_wstrb;
			end
			if (wr_fire) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				o_axi_bvalid <= 1'b1;
				o_axi_bresp <= (aw_addr == dpd_pkg::ADDR_DIRECT) ?
					dpd_pkg::RESP_OKAY : dpd_pkg::RESP_SLVERR;
			end else if (o_axi_bvalid && i_axi_bready)
				o_axi_bvalid <= 1'b0;
		end
	end

	logic [11:0] ar_addr;
	assign ar_addr = {i_axi_araddr[11:2], 2'h0};

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid <= 1'b0;
			o_axi_rdata <= 32'h0;
			o_axi_rresp <= dpd_pkg::RESP_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid <= 1'b1;
			o_axi_rresp <= dpd_pkg::RESP_OKAY;
			o_axi_rdata <= 32'h0;
			case (ar_addr)
				dpd_pkg::ADDR_IF_REF: o_axi_rdata <= {10'h0, lat[0]};
				dpd_pkg::ADDR_IF_AB: o_axi_rdata <= {10'h0, lat[1]};
				dpd_pkg::ADDR_RF_REF: o_axi_rdata <= {10'h0, lat[2]};
				dpd_pkg::ADDR_RF_AB: o_axi_rdata <= {10'h0, lat[3]};
				dpd_pkg::ADDR_DIRECT: o_axi_rdata <= 32'h0;
				dpd_pkg::ADDR_SHIFT: o_axi_rdata <= {10'h0, sreg};
				dpd_pkg::ADDR_STATUS: o_axi_rdata <= {29'h0, o_ref_input_isolation_switch,
					o_rf_power_down, o_if_power_down};
				default: o_axi_rresp <= dpd_pkg::RESP_SLVERR;
			endcase
		end else if (o_axi_rvalid) begin
			if (i_axi_rready) begin
				o_axi_rvalid <= 1'b0;
				o_axi_arready <= 1'b1;
			end
		end else
			o_axi_arready <= 1'b1;
	end

endmodule

/* tb/dpd_host_model.sv */
// Host side of the three-wire programming link.
// Assumes the bench calls send_word while no other word is in flight.
`timescale 1ns/1ps
module dpd_host_model (
	input wire logic i_clk,
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_load_strobe
);
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_load_strobe = 1'b0;
	end
	// MSB first, strobe low while shifting
	task automatic send_word(input logic [21:0] w);
		for (int i = 21; i >= 0; i--) begin
			@(posedge i_clk) o_ser_data <= w[i];
			repeat (2) @(posedge i_clk);
			o_ser_clk <= 1'b1;
			repeat (2) @(posedge i_clk);
			o_ser_clk <= 1'b0;
		end
		repeat (2) @(posedge i_clk);
		// Released data shows the inverse, never a stale bit
		o_ser_data <= ~w[0];
		o_load_strobe <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_load_strobe <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the dual synthesizer control block.
// Assumes the host model owns the serial pins; the bench drives the rest.
`timescale 1ns/1ps
module testbench;
	logic i_sys_clk, i_rst, ser_clk, ser_data, load, if_lock, rf_lock;
	logic [2:0] stim;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [4:0] pul;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic if_pd, rf_pd, iso, mux, oe;
	logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8};
	int cnt [5] = '{0, 0, 0, 0, 0};
	int nmux = 0;
	int n_fail = 0;
	int num_checks = 0;

	dpd_host_model host (.i_clk(i_sys_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
		.o_load_strobe(load));
	dpd_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ser_clk(ser_clk),
		.i_ser_data(ser_data), .i_load_strobe(load), .i_reference_input(stim[0]),
		.i_if_input(stim[1]), .i_rf_input(stim[2]), .i_if_lock(if_lock), .i_rf_lock(rf_lock),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid),
		.o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid),
		.i_axi_bready(bready), .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
		.o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
		.o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_if_ref_pulse(pul[0]),
		.o_if_fb_pulse(pul[1]), .o_rf_ref_pulse(pul[2]), .o_rf_fb_pulse(pul[3]),
		.o_if_power_down(if_pd), .o_rf_power_down(rf_pd),
		.o_ref_input_isolation_switch(iso), .o_test_mux_output(mux), .o_test_mux_oe(oe));
	// Thirteen-bit variant on the same pins; only its RF feedback pulse is watched
	dpd_ctrl #(.B13(1'b1)) dut_b13 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ser_clk(ser_clk),
		.i_ser_data(ser_data), .i_load_strobe(load), .i_reference_input(stim[0]),
		.i_if_input(stim[1]), .i_rf_input(stim[2]), .i_if_lock(if_lock), .i_rf_lock(rf_lock),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(),
		.i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid),
		.o_axi_wready(), .o_axi_bresp(), .o_axi_bvalid(),
		.i_axi_bready(bready), .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
		.o_axi_arready(), .o_axi_rdata(), .o_axi_rresp(),
		.o_axi_rvalid(), .i_axi_rready(rready), .o_if_ref_pulse(),
		.o_if_fb_pulse(), .o_rf_ref_pulse(), .o_rf_fb_pulse(pul[4]),
		.o_if_power_down(), .o_rf_power_down(),
		.o_ref_input_isolation_switch(), .o_test_mux_output(), .o_test_mux_oe());

	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// Pulse counts let period checks ignore divider phase
	always @(posedge i_sys_clk) begin
		for (int k = 0; k < 5; k++) begin
			if (pul[k] === 1'b1) cnt[k] <= cnt[k] + 1;
		end
		if (mux === 1'b1) nmux <= nmux + 1;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic bad(input string m);
		n_fail++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic timeout();
		bad("timeout");
		end_of_test();
	endtask
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) bad(m);
	endtask
	task automatic chk_per(input int g, input int e, input string m);
		num_checks++;
		if (g != e) bad(m);
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		int k;
		@(posedge i_sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h1;
		for (k = 0; k < 100; k++) begin
			@(posedge i_sys_clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
		if (k == 100) timeout();
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge i_sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge i_sys_clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		if (k == 100) timeout();
	endtask
	// Input edges until two pulses; per is the edge count between them
	// Six clocks per input edge keeps the counter rate low
	task automatic edges(input int sel, input int n, output int per);
		int first, c0, src;
		first = -1;
		per = -1;
		src = (sel % 2 == 0 && sel < 4) ? 0 : (sel + 1) / 2;
		for (int e = 1; e <= n && per < 0; e++) begin
			c0 = cnt[sel];
			@(posedge i_sys_clk) stim[src] <= 1'b1;
			repeat (2) @(posedge i_sys_clk);
			stim[src] <= 1'b0;
			repeat (3) @(posedge i_sys_clk);
			if (cnt[sel] != c0 && first < 0) first = e;
			else if (cnt[sel] != c0) per = e - first;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 7; k++) begin
			axi_rd(12'(4 * k), d, r);
			chk_val(d, 32'h0, "reset latch");
		end
		chk_val({27'h0, iso, rf_pd, if_pd, oe, mux}, 32'h2, "reset outputs");
	endtask
	task automatic t_latch();
		logic [31:0] d;
		logic [1:0] r;
		for (int s = 0; s < 4; s++) begin
			host.send_word({20'h0a5c3 + 20'(s), 2'(s)});
		end
		axi_rd(dpd_pkg::ADDR_SHIFT, d, r);
		chk_val(d, {10'h0, 20'h0a5c6, 2'h3}, "shift reg");
		for (int s = 0; s < 4; s++) begin
			axi_rd(12'(4 * s), d, r);
			chk_val(d, {10'h0, 20'h0a5c3 + 20'(s), 2'(s)}, "latch");
			chk_val({30'h0, r}, 32'h0, "read resp");
		end
	endtask
	task automatic t_div();
		int p;
		host.send_word({2'h0, 4'h0, 14'd3, 2'h0});
		edges(0, 12, p);
		chk_per(p, 3, "if ref div");
		host.send_word({2'h0, 4'h0, 14'd1, 2'h2});
		edges(2, 6, p);
		chk_per(p, 1, "rf ref div");
		host.send_word({2'h0, 11'd2, 1'b0, 6'd2, 2'h1});
		edges(1, 40, p);
		chk_per(p, 18, "if 8/9");
		host.send_word({2'h1, 11'd2, 1'b0, 6'd1, 2'h1});
		edges(1, 70, p);
		chk_per(p, 33, "if 16/17");
		host.send_word({2'h1, 11'd1, 1'b0, 6'd0, 2'h3});
		edges(3, 140, p);
		chk_per(p, 64, "rf 64/65");
		host.send_word({2'h0, 11'd3, 1'b0, 6'd2, 2'h3});
		edges(3, 200, p);
		chk_per(p, 98, "rf 32/33");
	endtask
	task automatic t_pd();
		logic [31:0] d;
		logic [1:0] r;
		int p;
		host.send_word({2'h2, 11'd1, 1'b0, 6'd0, 2'h1});
		chk_val({29'h0, iso, rf_pd, if_pd}, 32'h1, "if down");
		host.send_word({2'h2, 11'd1, 1'b0, 6'd0, 2'h3});
		axi_rd(dpd_pkg::ADDR_STATUS, d, r);
		chk_val(d, 32'h7, "both down");
		edges(0, 8, p);
		chk_per(p, -1, "ref gated");
		host.send_word({2'h0, 11'd1, 1'b0, 6'd0, 2'h1});
		chk_val({29'h0, iso, rf_pd, if_pd}, 32'h2, "if up");
	endtask
	task automatic t_mux();
		logic [3:0] c;
		logic e;
		int p;
		int m;
		for (int k = 0; k < 5; k++) begin
			c = codes[k];
			host.send_word({c[1:0], 4'h0, 14'd1, 2'h0});
			host.send_word({c[3:2], 4'h0, 14'd1, 2'h2});
			for (int l = 0; l < 4; l++) begin
				@(posedge i_sys_clk);
				if_lock <= l[0];
				rf_lock <= l[1];
				repeat (4) @(posedge i_sys_clk);
				e = c == 1 ? l[0] : c == 4 ? l[1] : c == 5 ? l[0] & l[1] : 1'b0;
				chk_val({oe, c < 8 ? mux : 1'b0}, {c < 8, e}, "test output");
			end
		end
		// Code 7: RF feedback divider on the test output, RF side woken with N = 32
		host.send_word({2'h3, 4'h0, 14'd1, 2'h0});
		host.send_word({2'h1, 4'h0, 14'd1, 2'h2});
		host.send_word({2'h0, 11'd1, 1'b0, 6'd0, 2'h3});
		m = nmux;
		edges(3, 80, p);
		chk_per(p, 32, "rf fb 32/33");
		chk_per(nmux - m, 2, "rf fb on test output");
	endtask
	task automatic t_b13();
		int p;
		host.send_word({2'h0, 13'd4, 5'd1, 2'h3});
		edges(4, 160, p);
		chk_per(p, 65, "b13 rf 16/17");
	endtask
	task automatic t_axi();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(dpd_pkg::ADDR_DIRECT, {10'h0, 11'd5, 1'b0, 6'd3, 2'h1}, 4'hf, r);
		chk_val({30'h0, r}, {30'h0, dpd_pkg::RESP_OKAY}, "direct resp");
		axi_wr(dpd_pkg::ADDR_IF_REF, 32'h3ffff1, 4'hf, r);
		chk_val({30'h0, r}, {30'h0, dpd_pkg::RESP_SLVERR}, "ro resp");
		axi_wr(dpd_pkg::ADDR_DIRECT, 32'h3ffff1, 4'h1, r);
		axi_rd(dpd_pkg::ADDR_IF_AB, d, r);
		chk_val(d, {10'h0, 11'd5, 1'b0, 6'd3, 2'h1}, "direct load");
		axi_rd(12'h020, d, r);
		chk_val({d[29:0], r}, {30'h0, dpd_pkg::RESP_SLVERR}, "unmapped");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		i_rst = 1'b1;
		stim = 3'h0;
		if_lock = 1'b0;
		rf_lock = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		t_reset();
		t_latch();
		t_div();
		t_pd();
		t_mux();
		t_axi();
		t_b13();
		end_of_test();
	end
endmodule
